// *** hdl/slave_event_pkg.sv ***
// Package with register map, field layout and bus carrier of the slave event block
package slave_event_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_EVENT_MASK = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_RAW_STATUS = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_MASKED_STATUS = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_EVENT_CLEAR = 12'h018;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int DATA_EVENT_BIT = 0;
  localparam logic RAW_RESET = 1'b0;
  localparam logic MASK_RESET = 1'b0;
  localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

  // Source indices into the pending vector
  localparam int SRC_RECEIVE = 0;
  localparam int SRC_TRANSMIT = 1;
  localparam int NUM_SOURCES = 2;

  // ----------------------------------------------------------------
  // Register bus request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

endpackage

// *** hdl/pending_rise_detect.sv ***
// Rising-edge detector that turns pending levels into one-cycle event pulses
`timescale 1ns/1ns
module pending_rise_detect
  import slave_event_pkg::*;
#(
  parameter int N = NUM_SOURCES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Levels in, pulses out
  input wire logic [N-1:0] level,
  output logic [N-1:0] rise
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (N < 1) begin : g_bad_n
    $error("pending_rise_detect needs at least one source");
  end

  logic [N-1:0] prev;
  logic [N-1:0] next_prev;

  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_comb begin
    next_prev = level;
  end

  // Reset to zero so a level already high at release counts as a new event
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_rise
    assign rise[i] = level[i] & ~prev[i];
  end

endmodule

// *** hdl/i2c_slave_irq_status.sv ***
// Data event status, mask, clear and interrupt logic of the slave unit
`timescale 1ns/1ns

// Behaviour
// R1 - Raw status bit 0 holds the data event, regardless of the mask.
// R2 - Masked status bit 0 shows an event signalled since the last clear; the code shows it only while mask enable is set.
// R3 - Writing one to clear register bit 0 clears the raw data event.
// R4 - Writing zero to clear register bit 0 leaves the raw event unchanged.
// R5 - Clear register is write-only; its read data carries no meaning.
// R6 - Software ignores reserved bits 31:1 and preserves them on updates.
// R7 - The raw event reaches the interrupt only while mask enable is set.
// R8 - Receive event means a received byte is waiting for software.
// R9 - Transmit event means addressed as transmitter and waiting for data.
// R10 - Masked bit is raw AND mask; it drives the interrupt output.
module i2c_slave_irq_status
  import slave_event_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire reg_req_t bus_req,
  output logic [DATA_W-1:0] rdata,
  // Slave core conditions
  input wire logic receive_pending,
  input wire logic transmit_pending,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Address decode helper
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------
  logic [NUM_SOURCES-1:0] pending;
  logic [NUM_SOURCES-1:0] pending_rise;
  logic data_event_set;

  assign pending[SRC_RECEIVE] = receive_pending;
  assign pending[SRC_TRANSMIT] = transmit_pending;

  pending_rise_detect #(
    .N(NUM_SOURCES)
  ) u_rise (
    .clk(clk),
    .rstn(rstn),
    .level(pending),
    .rise(pending_rise)
  );

  // Either the receive or the transmit condition raises the one data event
  assign data_event_set = |pending_rise; // see R8 see R9

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_mask;
  logic wr_clear;
  logic data_event_clear_bit;

  always_comb begin
    wr_mask = 1'b0;
    wr_clear = 1'b0;
    if (bus_req.wr && hit(bus_req.addr, OFF_EVENT_MASK)) begin
      wr_mask = 1'b1;
    end else if (bus_req.wr && hit(bus_req.addr, OFF_EVENT_CLEAR)) begin
      wr_clear = 1'b1;
    end
  end

  assign data_event_clear_bit = wr_clear & bus_req.wdata[DATA_EVENT_BIT];

  // ----------------------------------------------------------------
  // Mask register
  // ----------------------------------------------------------------
  logic data_event_mask_enable;
  logic next_data_event_mask_enable;

  always_comb begin
    next_data_event_mask_enable = data_event_mask_enable;
    if (wr_mask) begin
      next_data_event_mask_enable = bus_req.wdata[DATA_EVENT_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      data_event_mask_enable <= MASK_RESET;
    end else begin
      data_event_mask_enable <= next_data_event_mask_enable;
    end
  end

  // ----------------------------------------------------------------
  // Raw data event
  // ----------------------------------------------------------------
  logic raw_data_event;
  logic next_raw_data_event;

  // A new event in the clearing cycle wins, so no request is lost
  always_comb begin
    next_raw_data_event = raw_data_event;
    if (data_event_set) begin
      next_raw_data_event = 1'b1; // see R1
    end else if (data_event_clear_bit) begin
      next_raw_data_event = 1'b0; // see R3 see R4
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      raw_data_event <= RAW_RESET;
    end else begin
      raw_data_event <= next_raw_data_event;
    end
  end

  // ----------------------------------------------------------------
  // Masked view and interrupt
  // ----------------------------------------------------------------
  logic masked_data_event;

  assign masked_data_event = raw_data_event & data_event_mask_enable; // see R7 see R10
  assign irq = masked_data_event; // see R10

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  // Reserved bits and the write-only clear register read as zero
  always_comb begin
    next_rdata = READ_ZERO;
    if (bus_req.rd) begin
      if (hit(bus_req.addr, OFF_EVENT_MASK)) begin
        next_rdata[DATA_EVENT_BIT] = data_event_mask_enable;
      end else if (hit(bus_req.addr, OFF_RAW_STATUS)) begin
        next_rdata[DATA_EVENT_BIT] = raw_data_event; // see R1
      end else if (hit(bus_req.addr, OFF_MASKED_STATUS)) begin
        next_rdata[DATA_EVENT_BIT] = masked_data_event; // see R2
      end else if (hit(bus_req.addr, OFF_EVENT_CLEAR)) begin
        next_rdata = READ_ZERO; // see R5
      end
    end
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata <= READ_ZERO;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_rx_rise;
    $rose(receive_pending);
  endsequence

  sequence s_tx_rise;
    $rose(transmit_pending);
  endsequence

  sequence s_clear_one;
    bus_req.wr && bus_req.addr == OFF_EVENT_CLEAR && bus_req.wdata[DATA_EVENT_BIT];
  endsequence

  sequence s_clear_zero;
    bus_req.wr && bus_req.addr == OFF_EVENT_CLEAR && !bus_req.wdata[DATA_EVENT_BIT];
  endsequence

  property p_rx_sets_raw;
    @(posedge clk) disable iff (!rstn)
      s_rx_rise |=> raw_data_event;
  endproperty
  a_rx_sets_raw: assert property (p_rx_sets_raw) // see R8
    else $error("receive event did not set raw status");

  property p_tx_sets_raw;
    @(posedge clk) disable iff (!rstn)
      s_tx_rise |=> raw_data_event;
  endproperty
  a_tx_sets_raw: assert property (p_tx_sets_raw) // see R9
    else $error("transmit event did not set raw status");

  property p_clear_one;
    @(posedge clk) disable iff (!rstn)
      s_clear_one and !data_event_set |=> !raw_data_event;
  endproperty
  a_clear_one: assert property (p_clear_one) // see R3
    else $error("clear write did not clear raw status");

  property p_clear_zero_holds;
    @(posedge clk) disable iff (!rstn)
      s_clear_zero and raw_data_event |=> raw_data_event;
  endproperty
  a_clear_zero_holds: assert property (p_clear_zero_holds) // see R4
    else $error("zero clear write changed raw status");

  property p_raw_read;
    @(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr == OFF_RAW_STATUS
      |=> rdata == {{(DATA_W-1){1'b0}}, $past(raw_data_event)};
  endproperty
  a_raw_read: assert property (p_raw_read) // see R1
    else $error("raw status read returned wrong data");

  property p_masked_read;
    @(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr == OFF_MASKED_STATUS
      |=> rdata[DATA_EVENT_BIT] == $past(masked_data_event)
          && rdata[DATA_W-1:1] == '0;
  endproperty
  a_masked_read: assert property (p_masked_read) // see R2
    else $error("masked status read returned wrong data");

  property p_clear_read_zero;
    @(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr == OFF_EVENT_CLEAR |=> rdata == READ_ZERO;
  endproperty
  a_clear_read_zero: assert property (p_clear_read_zero) // see R5
    else $error("clear register read was not zero");

  property p_mask_blocks;
    @(posedge clk) disable iff (!rstn)
      bus_req.wr && bus_req.addr == OFF_EVENT_MASK && !bus_req.wdata[DATA_EVENT_BIT]
      |=> !irq;
  endproperty
  a_mask_blocks: assert property (p_mask_blocks) // see R7
    else $error("interrupt raised while mask enable clear");

  property p_irq_follows;
    @(posedge clk) disable iff (!rstn)
      s_rx_rise and data_event_mask_enable and !wr_mask |=> irq;
  endproperty
  a_irq_follows: assert property (p_irq_follows) // see R10
    else $error("enabled event did not raise the interrupt");

  property p_raw_sticky;
    @(posedge clk) disable iff (!rstn)
      raw_data_event && !(bus_req.wr && bus_req.addr == OFF_EVENT_CLEAR)
      |=> raw_data_event;
  endproperty
  a_raw_sticky: assert property (p_raw_sticky) // see R1
    else $error("raw status dropped without a clear");

  property p_set_wins;
    @(posedge clk) disable iff (!rstn)
      data_event_set |=> raw_data_event;
  endproperty
  a_set_wins: assert property (p_set_wins) // see R1
    else $error("new event lost against a clear write");

  property p_rx_beats_clear;
    @(posedge clk) disable iff (!rstn)
      s_rx_rise and s_clear_one |=> raw_data_event;
  endproperty
  a_rx_beats_clear: assert property (p_rx_beats_clear) // see R8
    else $error("receive event lost in the clearing cycle");

  property p_raw_needs_cause;
    @(posedge clk) disable iff (!rstn)
      $rose(raw_data_event) |-> $past(pending) != '0;
  endproperty
  a_raw_needs_cause: assert property (p_raw_needs_cause) // see R1
    else $error("raw status set with no pending condition");

  property p_mask_enables;
    @(posedge clk) disable iff (!rstn)
      bus_req.wr && bus_req.addr == OFF_EVENT_MASK && bus_req.wdata[DATA_EVENT_BIT]
      && raw_data_event |=> irq;
  endproperty
  a_mask_enables: assert property (p_mask_enables) // see R7
    else $error("pending event not forwarded after mask enable");

  property p_mask_read;
    @(posedge clk) disable iff (!rstn)
      bus_req.rd && bus_req.addr == OFF_EVENT_MASK
      |=> rdata == {{(DATA_W-1){1'b0}}, $past(data_event_mask_enable)};
  endproperty
  a_mask_read: assert property (p_mask_read) // see R7
    else $error("mask read returned wrong data");

  property p_clear_drops_irq;
    @(posedge clk) disable iff (!rstn)
      s_clear_one and !data_event_set |=> !irq;
  endproperty
  a_clear_drops_irq: assert property (p_clear_drops_irq) // see R10
    else $error("interrupt stayed high after a clear");

endmodule

// *** testbench/i2c_slave_irq_status_bench.sv ***
// Self-checking testbench of the slave data event status block
`timescale 1ns/1ns
module i2c_slave_irq_status_bench
  import slave_event_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic clk;
  logic rstn;
  reg_req_t bus_req;
  logic [DATA_W-1:0] rdata;
  logic receive_pending;
  logic transmit_pending;
  logic irq;
  int error_cnt;
  int checked;

  i2c_slave_irq_status dut_u (
    .clk(clk),
    .rstn(rstn),
    .bus_req(bus_req),
    .rdata(rdata),
    .receive_pending(receive_pending),
    .transmit_pending(transmit_pending),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rd(input string nm, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge clk);
    bus_req.rd <= 1'b0;
    #1;
    chk(nm, e, rdata);
  endtask

  task automatic chk_irq(input logic e);
    chk("irq", {31'h0000_0000, e}, {31'h0000_0000, irq});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    rd("raw", OFF_RAW_STATUS, 32'h0000_0000);
    rd("masked", OFF_MASKED_STATUS, 32'h0000_0000);
    rd("mask", OFF_EVENT_MASK, 32'h0000_0000);
    chk_irq(1'b0);
  endtask

  // Received byte while masked: raw shows it, interrupt stays quiet
  task automatic receive_masked();
    @(posedge clk);
    receive_pending <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rd("raw", OFF_RAW_STATUS, 32'h0000_0001);
    rd("masked", OFF_MASKED_STATUS, 32'h0000_0000);
    chk_irq(1'b0);
    wr(OFF_EVENT_CLEAR, 32'h0000_0000);
    rd("raw", OFF_RAW_STATUS, 32'h0000_0001);
  endtask

  // Unmask, read the clear register, then clear while still pending
  task automatic unmask_and_clear();
    wr(OFF_EVENT_MASK, 32'h0000_0001);
    chk_irq(1'b1);
    rd("mask", OFF_EVENT_MASK, 32'h0000_0001);
    rd("masked", OFF_MASKED_STATUS, 32'h0000_0001);
    rd("clear", OFF_EVENT_CLEAR, 32'h0000_0000);
    wr(OFF_EVENT_CLEAR, 32'h0000_0001);
    chk_irq(1'b0);
    rd("raw", OFF_RAW_STATUS, 32'h0000_0000);
    rd("masked", OFF_MASKED_STATUS, 32'h0000_0000);
    @(posedge clk);
    receive_pending <= 1'b0;
  endtask

  // Addressed as transmitter; read-only raw status refuses writes, unmapped place reads zero
  task automatic transmit_event();
    wr(OFF_RAW_STATUS, 32'h0000_0001);
    rd("raw", OFF_RAW_STATUS, 32'h0000_0000);
    @(posedge clk);
    transmit_pending <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_irq(1'b1);
    rd("raw", OFF_RAW_STATUS, 32'h0000_0001);
    rd("unmapped", 12'h01C, 32'h0000_0000);
    wr(OFF_EVENT_MASK, 32'h0000_0000);
    chk_irq(1'b0);
    rd("raw", OFF_RAW_STATUS, 32'h0000_0001);
    wr(OFF_EVENT_CLEAR, 32'h0000_0001);
    rd("raw", OFF_RAW_STATUS, 32'h0000_0000);
    @(posedge clk);
    transmit_pending <= 1'b0;
  endtask

  // A rise meeting a clear write wins; a level high at reset release is a new event
  task automatic race_and_reset();
    wr(OFF_EVENT_MASK, 32'h0000_0001);
    @(posedge clk);
    receive_pending <= 1'b1;
    bus_req.addr <= OFF_EVENT_CLEAR;
    bus_req.wdata <= 32'h0000_0001;
    bus_req.wr <= 1'b1;
    @(posedge clk);
    bus_req.wr <= 1'b0;
    #1;
    chk_irq(1'b1);
    rd("raw", OFF_RAW_STATUS, 32'h0000_0001);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk_irq(1'b0);
    rd("raw", OFF_RAW_STATUS, 32'h0000_0001);
    rd("mask", OFF_EVENT_MASK, 32'h0000_0000);
    wr(OFF_EVENT_CLEAR, 32'h0000_0001);
    rd("raw", OFF_RAW_STATUS, 32'h0000_0000);
    @(posedge clk);
    receive_pending <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Verdict and run control
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    // Generous margin over the fewer than a hundred cycles the scenarios need
    #8000;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    error_cnt = 0;
    checked = 0;
    rstn = 1'b0;
    bus_req = '0;
    receive_pending = 1'b0;
    transmit_pending = 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    reset_values();
    receive_masked();
    unmask_and_clear();
    transmit_event();
    race_and_reset();
    report_and_stop();
  end
endmodule
